/* src/capture_pkg.sv */
package capture_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  DCFG_OFS      = 8'h04;
    localparam logic [7:0]  STAT_OFS      = 8'h08;
    localparam logic [7:0]  TIME_OFS      = 8'h0C;
    localparam logic [7:0]  ERRC_OFS      = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_DIR_BIT  = 1;
    localparam int          DCFG_DROP_BIT = 4;
    localparam int          DCFG_P204_BIT = 5;
    localparam int          STAT_ALGN_BIT = 0;
    localparam int          STAT_LOCK_BIT = 1;
    localparam int          STAT_OVF_BIT  = 2;
    localparam int          STAT_RUN_BIT  = 3;
    localparam logic [2:0]  MODE_RST      = 3'h0;
    localparam logic [14:0] PRBS_SEED     = 15'h7FFF;

    // ------------------------------------------------------------
    // Symbol and packet constants
    // ------------------------------------------------------------
    localparam logic [3:0]  SYM_LAST      = 4'h9;
    localparam logic [3:0]  WORD_LAST     = 4'hF;
    localparam logic [9:0]  COMMA_POS     = 10'h0FA;
    localparam logic [9:0]  COMMA_NEG     = 10'h305;
    localparam logic [7:0]  TS_SYNC       = 8'h47;
    localparam logic [7:0]  TS_LEN_STD    = 8'hBC;
    localparam logic [7:0]  TS_LEN_ALT    = 8'hCC;
    localparam logic [7:0]  TS_PID_IDX    = 8'h02;
    localparam logic [12:0] NULL_PID      = 13'h1FFF;

    typedef enum logic [2:0] {
        MODE_RAW, MODE_ALIGN, MODE_DEC, MODE_DATA,
        MODE_TS, MODE_TSTAMP, MODE_PRBS, MODE_RSVD
    } mode_e;

endpackage

/* src/capture_formatter.sv */
`timescale 1ns/1ps

// Operation
// - Eight capture modes selectable: six acquisition modes, one test mode, one reserved.
// - Mode 0 forwards every received bit unchanged, in arrival order.
// - Mode 1 pads each ten-bit group to sixteen bits, padding on top.
// - Mode 1 word: zeros, aligned flag, new alignment flag, ten data bits.
// - Mode 2 decodes 8b/10b and prepends a status byte above the value.
// - Mode 2 word: zeros, valid, disparity error, code error, control, byte.
// - Mode 3 forwards only error-free decoded data bytes, drops the rest.
// - Mode 4 outputs packets; drop-null bit four removes idle packets.
// - Mode 5 outputs packets, always drops idle ones, adds timestamps.
// - Mode 6 sends an order-15 pseudo-random pattern instead of input.
// - Mode 7 is reserved and produces no output.
// - 188-byte packets start with sync byte 0x47, then three header bytes.
// - Header: error, start, 13-bit packet id, scramble, adaptation, counter.
// - The alternative 204-byte packet length is also accepted.
// - The channel is configurable as input or as output.
// - An external second pulse serves as the time source for timestamps.
// - With run clear the channel is held in reset and overflow cleared.
module capture_formatter
    import capture_pkg::*;
#(
    parameter int ERR_W = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial input and time source pins
    input  wire logic        rx_bit,
    input  wire logic        rx_carrier,
    input  wire logic        time_pps,
    // DMA word stream
    output logic      [15:0] dma_data,
    output logic             dma_valid,
    input  wire logic        dma_ready,
    // Channel direction
    output logic             chan_out_en
);
    import capture_pkg::*;

    if (ERR_W < 1 || ERR_W > 16) begin : g_chk
        $error("ERR_W must lie between 1 and 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic             pps_d;
        logic             run;
        logic             dir;
        mode_e            mode;
        logic             drop;
        logic             p204;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic [9:0]       sh;
        logic [3:0]       bcnt;
        logic             aligned;
        logic             newal;
        logic             rd;
        logic [15:0]      wsh;
        logic [3:0]       wcnt;
        logic [14:0]      prbs;
        logic [15:0]      dout;
        logic             dval;
        logic             ovf;
        logic [ERR_W-1:0] errc;
        logic [ERR_W-1:0] dispc;
        logic [31:0]      secs;
        logic [7:0]       bidx;
        logic             lock;
        logic             seen;
        logic [7:0]       p0;
        logic [7:0]       p1;
        logic [1:0]       pcnt;
        logic             dpkt;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // ------------------------------------------------------------
    // 8b/10b lookup
    // ------------------------------------------------------------
    function automatic logic [5:0] dec6(input logic [5:0] c);
        unique case (c)
            6'h27, 6'h18: dec6 = 6'h20;
            6'h1D, 6'h22: dec6 = 6'h21;
            6'h2D, 6'h12: dec6 = 6'h22;
            6'h31:        dec6 = 6'h23;
            6'h35, 6'h0A: dec6 = 6'h24;
            6'h29:        dec6 = 6'h25;
            6'h19:        dec6 = 6'h26;
            6'h38, 6'h07: dec6 = 6'h27;
            6'h39, 6'h06: dec6 = 6'h28;
            6'h25:        dec6 = 6'h29;
            6'h15:        dec6 = 6'h2A;
            6'h34:        dec6 = 6'h2B;
            6'h0D:        dec6 = 6'h2C;
            6'h2C:        dec6 = 6'h2D;
            6'h1C:        dec6 = 6'h2E;
            6'h17, 6'h28: dec6 = 6'h2F;
            6'h1B, 6'h24: dec6 = 6'h30;
            6'h23:        dec6 = 6'h31;
            6'h13:        dec6 = 6'h32;
            6'h32:        dec6 = 6'h33;
            6'h0B:        dec6 = 6'h34;
            6'h2A:        dec6 = 6'h35;
            6'h1A:        dec6 = 6'h36;
            6'h3A, 6'h05: dec6 = 6'h37;
            6'h33, 6'h0C: dec6 = 6'h38;
            6'h26:        dec6 = 6'h39;
            6'h16:        dec6 = 6'h3A;
            6'h36, 6'h09: dec6 = 6'h3B;
            6'h0E, 6'h0F, 6'h30: dec6 = 6'h3C;
            6'h2E, 6'h11: dec6 = 6'h3D;
            6'h1E, 6'h21: dec6 = 6'h3E;
            6'h2B, 6'h14: dec6 = 6'h3F;
            default:      dec6 = 6'h00;
        endcase
    endfunction

    function automatic logic [3:0] dec4(input logic [3:0] c);
        unique case (c)
            4'hB, 4'h4:       dec4 = 4'h8;
            4'h9:             dec4 = 4'h9;
            4'h5:             dec4 = 4'hA;
            4'hC, 4'h3:       dec4 = 4'hB;
            4'hD, 4'h2:       dec4 = 4'hC;
            4'hA:             dec4 = 4'hD;
            4'h6:             dec4 = 4'hE;
            4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'hF;
            default:          dec4 = 4'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        bit_in, take, comma, sym, kchar, cerr, derr, dbyte;
        logic        emit, tsm, nulp;
        logic [5:0]  d6;
        logic [3:0]  d4, ones;
        logic [7:0]  byte_v, len, nidx;
        logic [9:0]  shn;
        logic [15:0] word;
        bit_in = 1'b0;
        take   = 1'b0;
        comma  = 1'b0;
        sym    = 1'b0;
        kchar  = 1'b0;
        cerr   = 1'b0;
        derr   = 1'b0;
        dbyte  = 1'b0;
        emit   = 1'b0;
        tsm    = 1'b0;
        nulp   = 1'b0;
        d6     = 6'h00;
        d4     = 4'h0;
        ones   = 4'h0;
        byte_v = 8'h00;
        len    = 8'h00;
        nidx   = 8'h00;
        shn    = 10'h000;
        word   = 16'h0000;
        st_nxt = st_r;

        // Pin synchronisers and time source
        st_nxt.sync1 = {time_pps, rx_carrier, rx_bit};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.pps_d = st_r.sync2[2];
        if (st_r.sync2[2] && !st_r.pps_d) begin
            st_nxt.secs = st_r.secs + 32'h1;
        end

        // APB slave: zero wait state
        st_nxt.pready  = psel && !penable && !st_r.pready;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0;
        if (psel && !penable) begin
            st_nxt.pslverr = !(paddr == CTRL_OFS || paddr == DCFG_OFS ||
                               paddr == STAT_OFS || paddr == TIME_OFS ||
                               paddr == ERRC_OFS);
            unique case (paddr)
                CTRL_OFS: st_nxt.prdata = {30'h0, st_r.dir, st_r.run};
                DCFG_OFS: st_nxt.prdata = {26'h0, st_r.p204, st_r.drop,
                                           1'b0, st_r.mode};
                STAT_OFS: st_nxt.prdata = {28'h0, st_r.run, st_r.ovf,
                                           st_r.lock, st_r.aligned};
                TIME_OFS: st_nxt.prdata = st_r.secs;
                ERRC_OFS: st_nxt.prdata = {16'(st_r.dispc), 16'(st_r.errc)};
                default:  st_nxt.prdata = 32'h0;
            endcase
        end
        if (psel && penable && st_r.pready && pwrite) begin
            if (paddr == CTRL_OFS) begin
                st_nxt.run = pwdata[CTRL_RUN_BIT];
                st_nxt.dir = pwdata[CTRL_DIR_BIT];
            end
            if (paddr == DCFG_OFS) begin
                st_nxt.mode = mode_e'(pwdata[2:0]);
                st_nxt.drop = pwdata[DCFG_DROP_BIT];
                st_nxt.p204 = pwdata[DCFG_P204_BIT];
            end
        end

        // Symbol alignment and decode
        bit_in = st_r.sync2[0];
        take   = st_r.run && !st_r.dir && st_r.sync2[1];
        shn    = {st_r.sh[8:0], bit_in};
        comma  = shn == COMMA_POS || shn == COMMA_NEG;
        if (take) begin
            st_nxt.sh   = shn;
            st_nxt.bcnt = (st_r.bcnt == SYM_LAST) ? 4'h0 : st_r.bcnt + 4'h1;
            sym         = st_r.bcnt == SYM_LAST || comma;
            if (comma) begin
                st_nxt.bcnt    = 4'h0;
                st_nxt.aligned = 1'b1;
            end
        end
        d6    = dec6(shn[9:4]);
        d4    = dec4(shn[3:0]);
        kchar = shn[9:4] == 6'h0F || shn[9:4] == 6'h30 ||
                ((d6[4:0] == 5'h17 || d6[4:0] == 5'h1B || d6[4:0] == 5'h1D ||
                  d6[4:0] == 5'h1E) && (shn[3:0] == 4'h7 ||
                  shn[3:0] == 4'h8));
        cerr  = !d6[5] || !d4[3];
        for (int i = 0; i < 10; i++) begin
            ones = ones + {3'h0, shn[i]};
        end
        derr   = (ones == 4'h6 && st_r.rd) || (ones == 4'h4 && !st_r.rd) ||
                 ones < 4'h4 || ones > 4'h6;
        byte_v = {d4[2:0], d6[4:0]};
        dbyte  = sym && !cerr && !derr && !kchar;
        if (sym) begin
            if (ones != 4'h5) begin
                st_nxt.rd = ones > 4'h5;
            end
            st_nxt.newal = 1'b0;
            if (cerr) begin
                st_nxt.errc = st_r.errc + ERR_W'(1);
            end
            if (derr) begin
                st_nxt.dispc = st_r.dispc + ERR_W'(1);
            end
        end
        if (take && comma && st_r.bcnt != SYM_LAST) begin
            st_nxt.newal = 1'b1;
        end

        // Packet framer
        len  = st_r.p204 ? TS_LEN_ALT : TS_LEN_STD;
        nidx = (st_r.bidx == len - 8'h1) ? 8'h0 : st_r.bidx + 8'h1;
        tsm  = st_r.mode == MODE_TS || st_r.mode == MODE_TSTAMP;
        nulp = {st_r.p0[4:0], byte_v} == NULL_PID;
        if (dbyte && tsm) begin
            st_nxt.bidx = nidx;
            st_nxt.p0   = byte_v;
            st_nxt.p1   = st_r.p0;
            st_nxt.pcnt = (st_r.pcnt == 2'h2) ? 2'h2 : st_r.pcnt + 2'h1;
            if (!st_r.lock) begin
                st_nxt.pcnt = 2'h0;
                if (byte_v == TS_SYNC) begin
                    st_nxt.lock = st_r.seen && nidx == 8'h0;
                    st_nxt.seen = 1'b1;
                    st_nxt.bidx = 8'h0;
                    st_nxt.pcnt = 2'h1;
                end else if (nidx == 8'h0) begin
                    st_nxt.seen = 1'b0;
                end
            end else if (nidx == 8'h0 && byte_v != TS_SYNC) begin
                st_nxt.lock = 1'b0;
                st_nxt.seen = 1'b0;
                st_nxt.pcnt = 2'h0;
            end else if (nidx == TS_PID_IDX) begin
                st_nxt.dpkt = nulp && (st_r.drop ||
                              st_r.mode == MODE_TSTAMP);
            end
        end

        // Word assembly per mode
        unique case (st_r.mode)
            MODE_RAW: begin
                if (take) begin
                    st_nxt.wsh  = {st_r.wsh[14:0], bit_in};
                    st_nxt.wcnt = st_r.wcnt + 4'h1;
                    emit        = st_r.wcnt == WORD_LAST;
                    word        = {st_r.wsh[14:0], bit_in};
                end
            end
            MODE_ALIGN: begin
                emit = sym;
                word = {4'h0, st_nxt.aligned,
                        st_nxt.newal, shn};
            end
            MODE_DEC: begin
                emit = sym;
                word = {4'h0, !cerr && !derr, derr,
                        cerr, kchar, byte_v};
            end
            MODE_DATA: begin
                emit = dbyte;
                word = {8'h00, byte_v};
            end
            MODE_TS, MODE_TSTAMP: begin
                emit = dbyte && st_r.lock && st_nxt.lock &&
                       st_r.pcnt == 2'h2 && !st_nxt.dpkt;
                word = {7'h00, nidx == TS_PID_IDX, st_r.p1};
                if (st_r.mode == MODE_TSTAMP && nidx == TS_PID_IDX) begin
                    word[15:9] = st_r.secs[6:0];
                end
            end
            MODE_PRBS: begin
                if (st_r.run) begin
                    st_nxt.prbs = {st_r.prbs[13:0],
                                   st_r.prbs[14] ^ st_r.prbs[13]};
                    st_nxt.wsh  = {st_r.wsh[14:0], st_r.prbs[14]};
                    st_nxt.wcnt = st_r.wcnt + 4'h1;
                    emit        = st_r.wcnt == WORD_LAST;
                    word        = {st_r.wsh[14:0], st_r.prbs[14]};
                end
            end
            MODE_RSVD: begin
                emit = 1'b0;
            end
        endcase

        // Output register, one word in flight
        if (emit) begin
            st_nxt.dout = word;
            st_nxt.dval = 1'b1;
            if (st_r.dval && !dma_ready) begin
                st_nxt.ovf = 1'b1;
            end
        end else if (dma_ready) begin
            st_nxt.dval = 1'b0;
        end

        // Channel held in reset while not running
        if (!st_r.run) begin
            st_nxt.sh      = 10'h000;
            st_nxt.bcnt    = 4'h0;
            st_nxt.aligned = 1'b0;
            st_nxt.newal   = 1'b0;
            st_nxt.rd      = 1'b0;
            st_nxt.wsh     = 16'h0000;
            st_nxt.wcnt    = 4'h0;
            st_nxt.prbs    = PRBS_SEED;
            st_nxt.dval    = 1'b0;
            st_nxt.ovf     = 1'b0;
            st_nxt.errc    = '0;
            st_nxt.dispc   = '0;
            st_nxt.bidx    = 8'h0;
            st_nxt.lock    = 1'b0;
            st_nxt.seen    = 1'b0;
            st_nxt.pcnt    = 2'h0;
            st_nxt.dpkt    = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= '0;
            st_r.mode <= mode_e'(MODE_RST);
            st_r.prbs <= PRBS_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign dma_data    = st_r.dout;
    assign dma_valid   = st_r.dval;
    assign chan_out_en = st_r.dir;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_halt_clears: assert property (!st_r.run |=>
        !dma_valid && !st_r.ovf)
        else $error("channel not held while stopped");
    a_mode1_zeros: assert property (dma_valid && $changed(dma_data) &&
        st_r.mode == MODE_ALIGN |-> dma_data[15:12] == 4'h0)
        else $error("mode 1 word top bits not zero");
    a_mode2_flags: assert property (dma_valid && $changed(dma_data) &&
        st_r.mode == MODE_DEC |-> dma_data[15:12] == 4'h0 &&
        dma_data[11] == !(dma_data[10] || dma_data[9]))
        else $error("mode 2 status byte inconsistent");
    a_rsvd_silent: assert property (st_r.mode == MODE_RSVD &&
        !dma_valid |=> !dma_valid)
        else $error("reserved mode produced output");
    a_prbs_step: assert property (st_r.run && st_r.mode == MODE_PRBS &&
        $past(st_r.run) && $past(st_r.mode) == MODE_PRBS |->
        st_r.prbs[0] == ($past(st_r.prbs[14]) ^ $past(st_r.prbs[13])))
        else $error("pattern generator stepped wrongly");
    a_raw_period: assert property (st_r.mode == MODE_RAW && st_r.run &&
        st_r.sync2[1] && !st_r.dir && st_r.wcnt == WORD_LAST ##1
        st_r.mode == MODE_RAW |-> dma_valid && dma_data[0] ==
        $past(st_r.sync2[0]))
        else $error("raw word not emitted at bit sixteen");
    a_dir_blocks: assert property (st_r.dir && st_r.run |=>
        !$changed(st_r.sh))
        else $error("input captured in output direction");
    a_apb_answer: assert property (psel && !penable |=>
        pready ##1 !pready)
        else $error("APB answer not one cycle");
    a_lock_sync: assert property ($rose(st_r.lock) |->
        st_r.p0 == TS_SYNC)
        else $error("lock without sync byte");
    a_null_drop: assert property (dma_valid && $changed(dma_data) &&
        st_r.mode == MODE_TSTAMP |-> !st_r.dpkt)
        else $error("idle packet byte emitted");

    c_raw_word:  cover property (st_r.mode == MODE_RAW && $rose(dma_valid));
    c_ts_lock:   cover property ($rose(st_r.lock));
    c_realign:   cover property ($rose(st_r.newal));
    c_overflow:  cover property ($rose(st_r.ovf));
    c_null_drop: cover property ($rose(st_r.dpkt));

endmodule // capture_formatter

/* test/dma_sink.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// DMA consumer model
// ------------------------------------------------------------
module dma_sink (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Word stream
    input  wire logic [15:0] dma_data,
    input  wire logic        dma_valid,
    output logic             dma_ready,
    // Flow control from the bench
    input  wire logic        stall
);
    logic [15:0] words[$];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ready <= 1'b0;
        end else begin
            dma_ready <= !stall;
            if (dma_valid && dma_ready) begin
                words.push_back(dma_data);
            end
        end
    end
endmodule // dma_sink

/* test/tb_serial_video_capture_formatter.sv */
`timescale 1ns/1ps
module tb_serial_video_capture_formatter;
    import capture_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, stall = 0;
    logic        rx_bit = 0, rx_carrier = 0, time_pps = 0;
    logic [15:0] dma_data;
    logic        dma_valid, dma_ready, chan_out_en, r1, r2;
    logic [63:0] s;
    int          failures = 0, checks_done = 0, n;

    always #50 pclk = ~pclk;

    capture_formatter #(.ERR_W(16)) u_capture_formatter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_bit(rx_bit),
        .rx_carrier(rx_carrier), .time_pps(time_pps),
        .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready),
        .chan_out_en(chan_out_en));

    dma_sink u_dma_sink (
        .pclk(pclk), .presetn(presetn), .dma_data(dma_data),
        .dma_valid(dma_valid), .dma_ready(dma_ready), .stall(stall));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            $display("[FAIL] %0t no bus answer", $time);
            report_and_stop;
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    task send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge pclk);
            rx_carrier <= 1;
            rx_bit <= v[i];
        end
    endtask

    task idle(input int n);
        repeat (n) begin
            @(posedge pclk);
            rx_carrier <= 0;
            rx_bit <= ~rx_bit;
        end
    endtask

    task start(input logic [31:0] dcfg, input logic [31:0] ctrl);
        apb(1, CTRL_OFS, 0);
        apb(1, DCFG_OFS, dcfg);
        u_dma_sink.words.delete();
        apb(1, CTRL_OFS, ctrl);
    endtask

    function automatic logic found(input logic [15:0] a);
        for (int i = 0; i + 1 < u_dma_sink.words.size(); i++) begin
            if (u_dma_sink.words[i] === a
                && u_dma_sink.words[i+1] === 16'h00B5) return 1;
        end
        return 0;
    endfunction

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        $display("[FAIL] %0t run too long", $time);
        report_and_stop;
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, CTRL_OFS, 0); chk(rd, 0);
        apb(0, DCFG_OFS, 0); chk(rd, {29'h0, MODE_RST});
        apb(0, 8'h40, 0); chk(err, 1);
        chk(rd, 0);
        repeat (3) begin
            @(posedge pclk); time_pps <= 1;
            repeat (4) @(posedge pclk);
            time_pps <= 0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        apb(0, TIME_OFS, 0); chk(rd, 3);
        $display("test registers done");
        start(0, 1); send(16'hA5C3, 16); send(16'h1234, 16); idle(10);
        chk(u_dma_sink.words.size(), 2);
        chk(u_dma_sink.words[0], 16'hA5C3);
        chk(u_dma_sink.words[1], 16'h1234);
        start(0, 3); send(16'hA5C3, 16); idle(10);
        chk(chan_out_en, 1);
        chk(u_dma_sink.words.size(), 0);
        $display("test raw done");
        start(1, 1); send(COMMA_POS, 10); send(10'h2D1, 10); idle(10);
        chk(u_dma_sink.words[$], 16'h0AD1);
        start(2, 1); send(COMMA_POS, 10); send(10'h2AA, 10); idle(10);
        chk(u_dma_sink.words[$], 16'h08B5);
        start(3, 1); send(COMMA_POS, 10); send(10'h2AA, 10);
        send(COMMA_NEG, 10); send(10'h2AA, 10); idle(10);
        chk(u_dma_sink.words.size(), 2);
        chk(u_dma_sink.words[1], 16'h00B5);
        start(7, 1); send(16'hFFFF, 16); send(COMMA_POS, 10); idle(10);
        chk(u_dma_sink.words.size(), 0);
        $display("test symbol modes done");
        start(6, 1); idle(90);
        s = {u_dma_sink.words[0], u_dma_sink.words[1],
             u_dma_sink.words[2], u_dma_sink.words[3]};
        r1 = 1; r2 = 1;
        for (int t = 15; t < 64; t++) begin
            r1 &= s[63-t] == (s[64-t] ^ s[78-t]);
            r2 &= s[63-t] == (s[77-t] ^ s[78-t]);
        end
        chk((r1 | r2) && s != 0, 1);
        stall <= 1; idle(40);
        apb(0, STAT_OFS, 0);
        chk(rd[STAT_OVF_BIT], 1);
        chk(rd[STAT_RUN_BIT], 1);
        apb(1, CTRL_OFS, 0); stall <= 0;
        apb(0, STAT_OFS, 0); chk(rd[3:0], 0);
        chk(dma_valid, 0);
        $display("test pattern done");
        for (int k = 0; k < 3; k++) begin
            n = (k == 2) ? 204 : 188;
            start((k == 2) ? 32'h34 : k ? 32'h5 : 32'h14, 1);
            send(COMMA_POS, 10);
            for (int p = 0; p < 3; p++) begin
                send(10'h075, 10);
                if (p == 2) begin
                    repeat (2) send(10'h2B1, 10);
                end
                repeat ((p == 2) ? n - 3 : n - 1) send(10'h2AA, 10);
            end
            idle(30);
            apb(0, STAT_OFS, 0); chk(rd[STAT_LOCK_BIT], 1);
            chk(found((k == 1) ? 16'h0747 : 16'h0147), 1);
            chk(u_dma_sink.words.size(), n);
        end
        $display("test packets done");
        report_and_stop;
    end
endmodule // tb_serial_video_capture_formatter
